// >>> logic/adc_twi_device.sv
// Serial slave port and conversion sequencer of a small monitoring converter.
// Assumes a master on the link and a 12-bit sample source on i_sample.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Reset loads defaults, converter stays powered down
// - General call with 06h resets like power-up; the port keeps ptr_q, which only power-up clears
// - Mode bit one single-shot, zero continuous
// - Trigger write wakes, clears flag, converts once
// - Trigger during conversion is ignored
// - Continuous stores result, restarts with no gap
// - New settings apply after current conversion
// - Never drive clock; data only ack/read
// - Strap picks address, resampled each start
// - Bus rates up to 400 kbit/s only
// - Data changes only while clock low
// - Master frames transactions with start and stop
// - Address plus direction, ninth clock acknowledge
// - Bytes MSB first, receiver acknowledges each
// - 25 ms idle mid-transaction resets port
// - First write byte is register pointer
// - Registers move upper byte first
// - Master holds clock high when idle
// - Pointer retained across later reads
// - Settings write is pointer plus two bytes
// - Result reads zero until first conversion
module adc_twi_device #(
	parameter int unsigned TIMEOUT_LIM = adc_link_pkg::TIMEOUT_CYC,
	parameter int unsigned CONV_DIV = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	twi_link_if.device_mp link,
	input wire logic i_strap,
	input wire logic [11:0] i_sample,
	output logic [15:0] o_result,
	output logic [15:0] o_settings,
	output logic o_converting
);
	import adc_link_pkg::*;
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK} port_t;
	typedef enum logic [1:0] {C_DOWN, C_WAKE, C_CONV} conv_t;
	port_t st_q;
	conv_t cst_q;
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, strap_m, strap_s;
	logic start, stop, rise, fall, tmo;
	logic [19:0] idle_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q, tx_q, lo_q, hi_q, ptr_q;
	logic rw_q, gc_q, gc_hit_q, gc_rst_q, strap_lo_q, strap_sw_q, sel_lo_q, oe_q;
	logic [1:0] widx_q;
	logic wr_stb_q;
	logic [15:0] wr_val_q, rd_val;
	logic [6:0] my_addr;
	logic [14:0] set_q;
	logic trig_q;
	logic [15:0] res_q;
	logic [17:0] ccnt_q, conv_lim;
	logic [2:0] rate_q;
	logic srst;

	// Pins come from the master's domain
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			{scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3F;
			{strap_m, strap_s} <= 2'h0;
		end else begin
			{scl_m, scl_s, scl_p} <= {link.scl, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {link.sda, sda_m, sda_s};
			{strap_m, strap_s} <= {i_strap, strap_m};
		end
	end
	assign start = scl_s && scl_p && sda_p && !sda_s;
	assign stop = scl_s && scl_p && !sda_p && sda_s;
	assign rise = scl_s && !scl_p;
	assign fall = !scl_s && scl_p;

	// Strap low at start is ground; following the clock low is the clock tie
	always_comb begin
		if (strap_lo_q) my_addr = ADDR_GND;
		else if (strap_sw_q) my_addr = ADDR_SCL;
		else my_addr = ADDR_VDD;
	end
	assign rd_val = ptr_q == PTR_RESULT ? res_q : {trig_q, set_q};
	assign tmo = idle_q == 20'(TIMEOUT_LIM - 1);

	// Any line activity restarts the stall timer
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || st_q == S_IDLE || scl_s != scl_p || sda_s != sda_p) idle_q <= 20'h0;
		else idle_q <= idle_q + 20'h1;
	end

	always_ff @(posedge i_clk) begin
		wr_stb_q <= 1'b0;
		gc_rst_q <= 1'b0;
		if (!i_rst_n || tmo || stop) begin
			st_q <= S_IDLE;
			oe_q <= 1'b0;
			if (!i_rst_n) begin
				{cnt_q, sh_q, tx_q, lo_q, hi_q, ptr_q} <= 44'h0;
				{rw_q, gc_q, gc_hit_q, strap_lo_q, strap_sw_q, sel_lo_q} <= 6'h0;
				widx_q <= 2'h0;
				wr_val_q <= 16'h0;
			end
		end else if (start) begin
			st_q <= S_ADDR;
			cnt_q <= 4'h0;
			oe_q <= 1'b0;
			strap_lo_q <= !strap_s;
			strap_sw_q <= 1'b0;
		end else begin
			unique case (st_q)
				S_IDLE: oe_q <= 1'b0;
				S_ADDR: begin
					if (rise) sh_q <= {sh_q[6:0], sda_s};
					if (rise) cnt_q <= cnt_q + 4'h1;
					if (!scl_s && cnt_q == 4'h1 && !strap_s) strap_sw_q <= 1'b1;
					if (fall && cnt_q == 4'h8) begin
						if (sh_q[7:1] == my_addr || (sh_q[7:1] == ADDR_GCALL && !sh_q[0])) begin
							oe_q <= 1'b1;
							rw_q <= sh_q[0];
							gc_q <= sh_q[7:1] == ADDR_GCALL;
							gc_hit_q <= 1'b0;
							st_q <= S_AACK;
						end else begin
							st_q <= S_IDLE;
						end
					end
				end
				S_AACK: if (fall) begin
					cnt_q <= 4'h0;
					widx_q <= 2'h0;
					if (rw_q) begin
						tx_q <= rd_val[15:8];
						lo_q <= rd_val[7:0];
						sel_lo_q <= 1'b1;
						oe_q <= !rd_val[15];
						st_q <= S_RD;
					end else begin
						oe_q <= 1'b0;
						st_q <= S_WR;
					end
				end
				S_WR: begin
					if (rise) sh_q <= {sh_q[6:0], sda_s};
					if (rise) cnt_q <= cnt_q + 4'h1;
					if (fall && cnt_q == 4'h8) begin
						oe_q <= 1'b1;
						st_q <= S_WACK;
						if (widx_q != 2'h3) widx_q <= widx_q + 2'h1;
						if (gc_q) begin
							gc_hit_q <= widx_q == 2'h0 && sh_q == GC_RESET;
						end else if (widx_q == 2'h0) begin
							ptr_q <= sh_q;
						end else if (widx_q == 2'h1) begin
							hi_q <= sh_q;
						end else if (widx_q == 2'h2 && ptr_q == PTR_SETTINGS) begin
							wr_val_q <= {hi_q, sh_q};
							wr_stb_q <= 1'b1;
						end
					end
				end
				S_WACK: if (fall) begin
					oe_q <= 1'b0;
					cnt_q <= 4'h0;
					st_q <= S_WR;
					gc_rst_q <= gc_hit_q;
					gc_hit_q <= 1'b0;
				end
				S_RD: if (fall) begin
					cnt_q <= cnt_q + 4'h1;
					tx_q <= {tx_q[6:0], 1'b0};
					oe_q <= cnt_q != 4'h7 && !tx_q[6];
					if (cnt_q == 4'h7) st_q <= S_RACK;
				end
				default: begin
					if (rise && sda_s) st_q <= S_IDLE;
					if (fall) begin
						cnt_q <= 4'h0;
						st_q <= S_RD;
						sel_lo_q <= !sel_lo_q;
						tx_q <= sel_lo_q ? lo_q : rd_val[15:8];
						oe_q <= sel_lo_q ? !lo_q[7] : !rd_val[15];
						if (!sel_lo_q) lo_q <= rd_val[7:0];
					end
				end
			endcase
		end
	end
	// Only the data line is ever pulled, and only low
	assign link.sda_s_o = 1'b0;
	assign link.sda_s_oe = oe_q;

	assign srst = !i_rst_n || gc_rst_q;
	assign conv_lim = 18'(conv_cyc(rate_q) / CONV_DIV - 1);

	always_ff @(posedge i_clk) begin
		if (srst) begin
			cst_q <= C_DOWN;
			set_q <= SETTINGS_RESET[14:0];
			trig_q <= SETTINGS_RESET[TRIG_BIT];
			res_q <= 16'h0000;
			ccnt_q <= 18'h0;
			rate_q <= SETTINGS_RESET[RATE_LSB +: 3];
		end else begin
			ccnt_q <= ccnt_q + 18'h1;
			if (wr_stb_q) set_q <= wr_val_q[14:0];
			unique case (cst_q)
				C_DOWN: begin
					ccnt_q <= 18'h0;
					if (wr_stb_q && wr_val_q[MODE_BIT] && wr_val_q[TRIG_BIT]) begin
						cst_q <= C_WAKE;
						trig_q <= 1'b0;
					end else if (!set_q[MODE_BIT] && !wr_stb_q) begin
						cst_q <= C_WAKE;
						trig_q <= 1'b0;
					end
				end
				C_WAKE: if (ccnt_q == 18'(WAKE_CYC - 1)) begin
					cst_q <= C_CONV;
					ccnt_q <= 18'h0;
					rate_q <= set_q[RATE_LSB +: 3];
				end
				default: if (ccnt_q == conv_lim) begin
					res_q <= {i_sample, 4'h0};
					ccnt_q <= 18'h0;
					rate_q <= set_q[RATE_LSB +: 3];
					if (set_q[MODE_BIT]) begin
						cst_q <= C_DOWN;
						trig_q <= 1'b1;
					end
				end
			endcase
			// Trigger writes while busy fall through untouched
		end
	end

	always_ff @(posedge i_clk) begin
		if (srst) begin
			o_result <= 16'h0000;
			o_settings <= SETTINGS_RESET;
			o_converting <= 1'b0;
		end else begin
			o_result <= res_q;
			o_settings <= {trig_q, set_q};
			o_converting <= cst_q != C_DOWN;
		end
	end
endmodule
`default_nettype wire

// >>> logic/adc_link_pkg.sv
// Constants shared by the converter's serial port and the bus master.
// Assumes a 25 MHz system clock on both ends.
package adc_link_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned WAKE_NS = 25_000;
	localparam int unsigned WAKE_CYC = (WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned TIMEOUT_MS = 25;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned SCL_KBPS = 400;
	localparam int unsigned SCL_QTR = (CLK_HZ + SCL_KBPS * 4000 - 1) / (SCL_KBPS * 4000);
	localparam logic [6:0] ADDR_GND = 7'h48;
	localparam logic [6:0] ADDR_VDD = 7'h49;
	localparam logic [6:0] ADDR_SCL = 7'h4B;
	localparam logic [6:0] ADDR_GCALL = 7'h00;
	localparam logic [7:0] GC_RESET = 8'h06;
	localparam logic [7:0] PTR_RESULT = 8'h00;
	localparam logic [7:0] PTR_SETTINGS = 8'h01;
	localparam logic [15:0] SETTINGS_RESET = 16'h8583;
	localparam int unsigned TRIG_BIT = 15;
	localparam int unsigned MODE_BIT = 8;
	localparam int unsigned RATE_LSB = 5;
	localparam logic [7:0] REG_TARGET = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	typedef enum logic [1:0] {OP_PTR, OP_WRITE, OP_READ, OP_GCALL} op_t;

	// Conversion length in system clocks for each rate code
	function automatic int unsigned conv_cyc(input logic [2:0] rate);
		unique case (rate)
			3'h0: conv_cyc = CLK_HZ / 128;
			3'h1: conv_cyc = CLK_HZ / 250;
			3'h2: conv_cyc = CLK_HZ / 490;
			3'h3: conv_cyc = CLK_HZ / 920;
			3'h4: conv_cyc = CLK_HZ / 1600;
			3'h5: conv_cyc = CLK_HZ / 2400;
			default: conv_cyc = CLK_HZ / 3300;
		endcase
	endfunction
endpackage

// >>> logic/twi_link_if.sv
// Two-wire link between the bus master and the converter.
// Open-drain wires are resolved here from the output enables.
`timescale 1ns/100ps
`default_nettype none
interface twi_link_if;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;
	assign scl = scl_m_oe ? scl_m_o : 1'b1;
	assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
	modport device_mp (input scl, input sda, output sda_s_o, output sda_s_oe);
	modport master_mp (input scl, input sda, output scl_m_o, output scl_m_oe,
		output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// >>> logic/twi_bus_master.sv
// Two-wire bus master with an AXI4-Lite register front end.
// Assumes one slave that never stretches the clock.
`timescale 1ns/100ps
`default_nettype none
module twi_bus_master (
	input wire logic i_clk,
	input wire logic i_rst_n,
	twi_link_if.master_mp link,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready
);
	import adc_link_pkg::*;
	typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} mst_t;
	mst_t st_q;
	logic aw_got_q, w_got_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [6:0] target_q;
	logic [15:0] wr_val_q, rd_val_q;
	logic [7:0] ptr_q;
	op_t op_q;
	logic busy_q, nack_q;
	logic [7:0] div_q;
	logic [1:0] ph_q, bi_q, last_q;
	logic [3:0] k_q;
	logic sda_m, sda_s;
	logic do_wr, tick, rx_byte;
	logic [7:0] tx_byte;

	assign o_s_axi_awready = !aw_got_q && !o_s_axi_bvalid;
	assign o_s_axi_wready = !w_got_q && !o_s_axi_bvalid;
	assign o_s_axi_arready = !o_s_axi_rvalid;
	assign do_wr = aw_got_q && w_got_q && !o_s_axi_bvalid;
	assign link.scl_m_o = 1'b0;
	assign link.sda_m_o = 1'b0;

	// Write address and data are taken independently; the write lands once both are in
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= 2'h0;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= i_s_axi_wdata;
			end
			if (do_wr) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				unique case (awaddr_q)
					REG_TARGET, REG_WDATA, REG_CMD: o_s_axi_bresp <= 2'h0;
					default: o_s_axi_bresp <= 2'h2;
				endcase
			end else if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= 2'h0;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp <= 2'h0;
			unique case (i_s_axi_araddr)
				REG_TARGET: o_s_axi_rdata <= {25'h0, target_q};
				REG_WDATA: o_s_axi_rdata <= {16'h0, wr_val_q};
				REG_CMD: o_s_axi_rdata <= {16'h0, ptr_q, 6'h0, op_q};
				REG_STATUS: o_s_axi_rdata <= {30'h0, nack_q, busy_q};
				REG_RDATA: o_s_axi_rdata <= {16'h0, rd_val_q};
				default: begin
					o_s_axi_rdata <= 32'h0000_0000;
					o_s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (o_s_axi_rvalid && i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
		end
	end

	// Data line comes from another device's pin
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			sda_m <= link.sda;
			sda_s <= sda_m;
		end
	end

	assign tick = div_q == 8'(SCL_QTR - 1);
	assign rx_byte = op_q == OP_READ && bi_q != 2'h0;
	always_comb begin
		tx_byte = 8'hFF;
		if (bi_q == 2'h0) begin
			tx_byte = op_q == OP_GCALL ? {ADDR_GCALL, 1'b0} : {target_q, op_q == OP_READ};
		end else if (op_q == OP_GCALL) begin
			tx_byte = GC_RESET;
		end else if (op_q != OP_READ) begin
			unique case (bi_q)
				2'h1: tx_byte = ptr_q;
				2'h2: tx_byte = wr_val_q[15:8];
				default: tx_byte = wr_val_q[7:0];
			endcase
		end
	end

	// Each bit is four quarter periods: set data, raise clock, sample, lower clock
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_q <= M_IDLE;
			target_q <= ADDR_GND;
			wr_val_q <= 16'h0000;
			rd_val_q <= 16'h0000;
			ptr_q <= 8'h00;
			op_q <= OP_PTR;
			busy_q <= 1'b0;
			nack_q <= 1'b0;
			div_q <= 8'h00;
			ph_q <= 2'h0;
			bi_q <= 2'h0;
			last_q <= 2'h0;
			k_q <= 4'h0;
			link.scl_m_oe <= 1'b0;
			link.sda_m_oe <= 1'b0;
		end else begin
			div_q <= (st_q == M_IDLE || tick) ? 8'h00 : div_q + 8'h01;
			if (do_wr && awaddr_q == REG_TARGET) target_q <= wdata_q[6:0];
			if (do_wr && awaddr_q == REG_WDATA) wr_val_q <= wdata_q[15:0];
			unique case (st_q)
				M_IDLE: begin
					if (do_wr && awaddr_q == REG_CMD) begin
						op_q <= op_t'(wdata_q[1:0]);
						ptr_q <= wdata_q[15:8];
						busy_q <= 1'b1;
						nack_q <= 1'b0;
						ph_q <= 2'h0;
						unique case (op_t'(wdata_q[1:0]))
							OP_WRITE: last_q <= 2'h3;
							OP_READ: last_q <= 2'h2;
							default: last_q <= 2'h1;
						endcase
						st_q <= M_START;
					end
				end
				M_START: if (tick) begin
					ph_q <= ph_q + 2'h1;
					if (ph_q == 2'h1) link.sda_m_oe <= 1'b1;
					if (ph_q == 2'h2) link.scl_m_oe <= 1'b1;
					if (ph_q == 2'h3) begin
						st_q <= M_BIT;
						bi_q <= 2'h0;
						k_q <= 4'h0;
					end
				end
				M_BIT: if (tick) begin
					ph_q <= ph_q + 2'h1;
					unique case (ph_q)
						2'h0: begin
							if (k_q != 4'h8) link.sda_m_oe <= !rx_byte && !tx_byte[3'h7 - k_q[2:0]];
							else link.sda_m_oe <= rx_byte && bi_q != last_q;
						end
						2'h1: link.scl_m_oe <= 1'b0;
						2'h2: begin
							if (k_q != 4'h8 && rx_byte) rd_val_q <= {rd_val_q[14:0], sda_s};
							if (k_q == 4'h8 && !rx_byte && sda_s) nack_q <= 1'b1;
						end
						default: begin
							link.scl_m_oe <= 1'b1;
							k_q <= k_q + 4'h1;
							if (k_q == 4'h8) begin
								k_q <= 4'h0;
								bi_q <= bi_q + 2'h1;
								if (nack_q || bi_q == last_q) st_q <= M_STOP;
							end
						end
					endcase
				end
				default: if (tick) begin
					ph_q <= ph_q + 2'h1;
					if (ph_q == 2'h0) link.sda_m_oe <= 1'b1;
					if (ph_q == 2'h1) link.scl_m_oe <= 1'b0;
					if (ph_q == 2'h2) link.sda_m_oe <= 1'b0;
					if (ph_q == 2'h3) begin
						st_q <= M_IDLE;
						busy_q <= 1'b0;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> tb/adc_link_checker.sv
// Concurrent checks on the two-wire link between master and device.
// Assumes both ends share i_clk and sit on one interface instance.
`timescale 1ns/100ps
`default_nettype none
module adc_link_checker #(
	parameter int unsigned TIMEOUT_LIM = 2000
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_o,
	input wire logic sda_s_oe
);
	logic scl_d_q;
	logic sda_d_q;
	logic [9:0] per_q;
	logic [9:0] hi_q;
	logic [15:0] oe_q;
	logic [7:0] rise_q;
	logic rise;
	logic start_evt;
	logic stop_evt;
	assign rise = scl && !scl_d_q;
	assign start_evt = scl && scl_d_q && sda_d_q && !sda;
	assign stop_evt = scl && scl_d_q && !sda_d_q && sda;
	always_ff @(posedge i_clk) begin
		scl_d_q <= scl;
		sda_d_q <= sda;
	end
	// Saturating, so a long idle never wraps into a false short period
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) per_q <= 10'h3FF;
		else if (rise) per_q <= 10'h001;
		else if (per_q != 10'h3FF) per_q <= per_q + 10'h001;
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !scl) hi_q <= 10'h000;
		else if (hi_q != 10'h3FF) hi_q <= hi_q + 10'h001;
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !sda_s_oe) oe_q <= 16'h0000;
		else if (oe_q != 16'hFFFF) oe_q <= oe_q + 16'h0001;
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || start_evt) rise_q <= 8'h00;
		else if (rise) rise_q <= rise_q + 8'h01;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_slave_open_drain: assert property (sda_s_oe |-> !sda_s_o)
		else $error("device drives data high");
	a_slave_moves_low: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("device data changed while clock high");
	a_idle_release: assert property (hi_q >= 10'd48 |-> !sda_s_oe)
		else $error("device holds data on idle bus");
	a_ack_held: assert property ($rose(sda_s_oe) |-> sda_s_oe [*8])
		else $error("device pull-low too short");
	a_drive_bounded: assert property (oe_q < 16'(TIMEOUT_LIM))
		else $error("device holds data beyond timeout");
	a_rate_limit: assert property (rise |-> per_q >= 10'd63)
		else $error("clock period below fast-mode limit");
	a_start_hold: assert property (start_evt |-> scl [*4])
		else $error("clock dropped right after start");
	a_stop_release: assert property (stop_evt |-> sda [*4])
		else $error("data dropped right after stop");
	// The stop's own clock rise follows the last nine-clock unit
	a_bit_count: assert property (stop_evt |-> rise_q % 8'd9 == 8'd1)
		else $error("frame not whole nine-clock units");
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Bench: register bus drives the master, which talks to the device.
// A second device on its own link is bit-banged to stall a transfer.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import adc_link_pkg::*;
	localparam int unsigned TO_LIM = 2000;
	localparam int LIMIT = 99000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, converting, strap;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] result, settings;
	logic [1:0] strap_mode = 2'h0;
	logic sweep = 1'b0;
	logic armed = 1'b0;
	logic conv_prev = 1'b0;
	logic [11:0] sample = 12'hA5C;
	logic [15:0] res_prev = 16'h0;
	logic [15:0] set_prev = 16'h0;
	logic [6:0] addrs [3] = '{7'h48, 7'h49, 7'h4B};
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0, rises = 0, falls = 0, gap = 0, last_gap = 0, after_gap = 0;
	int hi_cnt = 0, last_hi = 0, n0 = 0;
	twi_link_if l1();
	twi_link_if l2();
	// Strap tied to the clock line is the third address choice
	assign strap = (strap_mode == 2'h2) ? l1.scl : strap_mode[0];
	always #20 clk = ~clk;
	twi_bus_master i_twi_bus_master (.i_clk(clk), .i_rst_n(rst_n), .link(l1),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));
	adc_twi_device #(.TIMEOUT_LIM(TO_LIM), .CONV_DIV(16)) i_adc_twi_device (.i_clk(clk),
		.i_rst_n(rst_n), .link(l1), .i_strap(strap), .i_sample(sample), .o_result(result),
		.o_settings(settings), .o_converting(converting));
	adc_twi_device #(.TIMEOUT_LIM(TO_LIM), .CONV_DIV(16)) i_adc_twi_device_b (.i_clk(clk),
		.i_rst_n(rst_n), .link(l2), .i_strap(1'b0), .i_sample(sample), .o_result(),
		.o_settings(), .o_converting());
	adc_link_checker #(.TIMEOUT_LIM(TO_LIM)) i_adc_link_checker (.i_clk(clk), .i_rst_n(rst_n),
		.scl(l1.scl), .sda(l1.sda), .sda_s_o(l1.sda_s_o), .sda_s_oe(l1.sda_s_oe));

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	// Monitor: conversion run lengths and gaps between result updates
	always @(posedge clk) begin
		cyc++;
		if (sweep) sample <= sample + 12'h001;
		if (converting && !conv_prev) rises++;
		if (!converting && conv_prev) begin
			falls++;
			last_hi = hi_cnt;
			hi_cnt = 0;
		end
		if (converting) hi_cnt++;
		conv_prev = converting;
		if (settings !== set_prev) armed = 1'b1;
		set_prev = settings;
		gap++;
		if (result !== res_prev) begin
			if (armed) after_gap = gap;
			armed = 1'b0;
			last_gap = gap;
			gap = 0;
		end
		res_prev = result;
		if (cyc == LIMIT) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic run_cmd(input op_t op, input logic [7:0] ptr, input logic [15:0] wd);
		logic [31:0] st;
		logic [1:0] r;
		axi_wr(REG_WDATA, {16'h0, wd});
		axi_wr(REG_CMD, {16'h0, ptr, 6'h00, op});
		do axi_rd(REG_STATUS, st, r); while (st[0] !== 1'b0);
	endtask
	task automatic link_rd(input logic do_ptr, input logic [7:0] ptr, input logic [15:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		if (do_ptr) run_cmd(OP_PTR, ptr, 16'h0);
		run_cmd(OP_READ, 8'h00, 16'h0);
		axi_rd(REG_RDATA, d, r);
		chk(d, {16'h0, exp});
	endtask
	task automatic wait_change();
		logic [15:0] r;
		r = result;
		do @(posedge clk); while (result === r);
		@(negedge clk);
	endtask
	task automatic bb_half(input logic scl_low, input logic sda_low, input int n);
		l2.scl_m_oe <= scl_low;
		l2.sda_m_oe <= sda_low;
		repeat (n) @(posedge clk);
	endtask
	// Start, address byte, then the ninth clock left high: a stalled master
	task automatic bb_addr(input logic [7:0] a, output logic ack);
		@(posedge clk);
		bb_half(1'b0, 1'b1, 16);
		for (int i = 7; i >= 0; i--) begin
			bb_half(1'b1, l2.sda_m_oe, 16);
			bb_half(1'b1, ~a[i], 16);
			bb_half(1'b0, ~a[i], 32);
		end
		bb_half(1'b1, 1'b0, 32);
		bb_half(1'b0, 1'b0, 8);
		ack = ~l2.sda;
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic ack;
		l2.scl_m_o = 1'b0;
		l2.sda_m_o = 1'b0;
		l2.scl_m_oe = 1'b0;
		l2.sda_m_oe = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(settings, 16'h8583);
		chk(converting, 1'b0);
		link_rd(1'b1, PTR_RESULT, 16'h0000);
		link_rd(1'b1, PTR_SETTINGS, 16'h8583);
		link_rd(1'b0, 8'h00, 16'h8583);
		chk(rises, 0);
		$display("test defaults done");
		n0 = rises;
		run_cmd(OP_WRITE, PTR_SETTINGS, 16'h8503);
		link_rd(1'b1, PTR_SETTINGS, 16'h0503);
		run_cmd(OP_WRITE, PTR_SETTINGS, 16'h8503);
		do @(posedge clk); while (converting);
		@(negedge clk);
		// Wake plus one rate-0 conversion; a restart would stretch it
		chk(last_hi >= WAKE_CYC + 12207 && last_hi <= WAKE_CYC + 12211, 1);
		chk(result, 16'hA5C0);
		link_rd(1'b1, PTR_SETTINGS, 16'h8503);
		chk(rises - n0, 1);
		$display("test single_shot done");
		sweep <= 1'b1;
		n0 = falls;
		run_cmd(OP_WRITE, PTR_SETTINGS, 16'h0483);
		repeat (3) wait_change();
		chk(last_gap, 976);
		run_cmd(OP_WRITE, PTR_SETTINGS, 16'h0423);
		wait_change();
		wait_change();
		chk(after_gap, 976);
		chk(last_gap, 6250);
		chk(falls - n0, 0);
		$display("test continuous done");
		run_cmd(OP_GCALL, 8'h00, 16'h0);
		chk(settings, 16'h8583);
		chk(result, 16'h0000);
		link_rd(1'b1, PTR_SETTINGS, 16'h8583);
		chk(converting, 1'b0);
		axi_rd(8'h14, d, r);
		chk(r, 2'h2);
		chk(d, 32'h0);
		$display("test general_call done");
		for (int m = 0; m < 3; m++) begin
			for (int k = 0; k < 2; k++) begin
				strap_mode <= 2'(m);
				axi_wr(REG_TARGET, {25'h0, addrs[(m + k) % 3]});
				run_cmd(OP_PTR, PTR_SETTINGS, 16'h0);
				axi_rd(REG_STATUS, d, r);
				chk(d[1], k != 0);
			end
		end
		$display("test address_strap done");
		bb_addr(8'h90, ack);
		chk(ack, 1'b1);
		repeat (100) @(posedge clk);
		chk(l2.sda, 1'b0);
		repeat (TO_LIM + 200) @(posedge clk);
		chk(l2.sda, 1'b1);
		bb_addr(8'h90, ack);
		chk(ack, 1'b1);
		bb_half(1'b1, 1'b1, 32);
		bb_half(1'b0, 1'b1, 16);
		bb_half(1'b0, 1'b0, 16);
		$display("test timeout done");
		give_verdict();
	end
endmodule
`default_nettype wire
